//--- src/cmb_msg_store.sv
// Behaviour
// - transmit pin low means dominant, high recessive; receive pin is input.
// - received frames pass a background then foreground two-stage buffer.
// - each receive buffer holds thirteen bytes of control, identifier, data.
// - rx full flag set while foreground holds accepted good frame.
// - every incoming frame overwrites background, regardless of filter result, except while both buffers are full.
// - accepted frame with full flag clear copies to foreground, sets flag.
// - next frame may be received right after the inter-frame space.
// - own frames outside loop-back stay in background, no ack, no flag.
// - in loop-back own frames handled like any received frame.
// - after lost arbitration the winning frame is received normally.
// - both buffers full and new accepted frame: discard, flag overrun.
// - while both buffers full, transmit continues, incoming frames dropped.
// - three transmit buffers, thirteen bytes plus eight-bit local priority.
// - successful transmit sets that buffer's empty flag.
// - lowest local priority value among pending buffers is sent first.
// - selection reruns at every arbitration, including error retries.
// - a frame already on the bus is never aborted.
// - abort request, when possible, sets abort acknowledge and empty flag.
// - abort acknowledge reads one after abort, zero after transmission.
// - flags clear by writing one; writing zero leaves them.
// - a flag stays set while its setting condition persists.
//
// Design decisions made here: the address-and-strobe port and the address map.
module cmb_msg_store
   import cmb_pkg::*;
#(
   parameter int unsigned TX_BUFS = CMB_TX_BUFS
) (
   input wire logic sys_clk,             // 100 MHz clock
   input wire logic reset,               // synchronous, active high
   input wire cmb_bus_req_t bus_req,     // register port request
   output logic [7:0] bus_rdata,         // read data, cycle after rd
   input wire logic bus_receive_pin,     // bus level from transceiver
   input wire logic engine_tx_bit,       // bit from protocol engine, 0 dominant
   input wire logic engine_tx_active,    // engine is driving a frame
   output logic bus_transmit_pin,        // to transceiver
   output logic engine_rx_bit,           // bus level to engine
   input wire cmb_rx_evt_t rx_evt,       // receive events from engine
   input wire cmb_tx_evt_t tx_evt,       // transmit events from engine
   output logic ack_enable,              // engine may acknowledge this frame
   output logic tx_pending,              // some buffer scheduled
   output logic [1:0] tx_sel,            // buffer chosen at arbitration
   output logic [7:0] tx_byte,           // byte of selected buffer
   input wire logic [3:0] tx_byte_idx,   // byte index asked by engine
   output logic loopback,                // loop-back mode to engine
   output logic rx_irq_req,              // receive event, masked by rxie
   output logic tx_irq_req,              // transmit event, unmasked
   output logic ovr_irq_req              // overrun event, masked by rxie
);
   logic [7:0] bg_q [CMB_FRAME_BYTES];
   logic [7:0] bg_d [CMB_FRAME_BYTES];
   logic [7:0] fg_q [CMB_FRAME_BYTES];
   logic [7:0] fg_d [CMB_FRAME_BYTES];
   logic [7:0] txb_q [TX_BUFS][CMB_FRAME_BYTES];
   logic [7:0] txb_d [TX_BUFS][CMB_FRAME_BYTES];
   logic [7:0] local_priority_field_q [TX_BUFS];
   logic [7:0] local_priority_field_d [TX_BUFS];
   logic rxf_q;
   logic rxf_d;
   logic ovr_q;
   logic ovr_d;
   logic bg_full_q;
   logic bg_full_d;
   logic [TX_BUFS-1:0] txe_q;
   logic [TX_BUFS-1:0] txe_d;
   logic [TX_BUFS-1:0] abort_request_q;
   logic [TX_BUFS-1:0] abort_request_d;
   logic [TX_BUFS-1:0] abort_acknowledge_q;
   logic [TX_BUFS-1:0] abort_acknowledge_d;
   logic [7:0] rxie_q;
   logic [7:0] rxie_d;
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [1:0] sel_q;
   logic [1:0] sel_d;
   logic busy_q;
   logic busy_d;

   function automatic logic take_frame(input cmb_rx_evt_t e, input logic lb);
      take_frame = !e.own || lb || e.arb_lost;
   endfunction : take_frame

   // one window of sixteen addresses per transmit buffer
   function automatic logic txb_hit(input logic [7:0] addr, input int unsigned n);
      txb_hit = addr[7:4] == (CMB_TXB_BASE[7:4] + 4'(n));
   endfunction : txb_hit

   assign loopback = ctl_q[CMB_LOOP_BIT];
   // loop-back closes the pin internally and holds the bus recessive
   assign bus_transmit_pin = loopback ? 1'b1 : (engine_tx_active ? engine_tx_bit : 1'b1);
   assign engine_rx_bit = loopback ? engine_tx_bit : bus_receive_pin;
   assign ack_enable = take_frame(rx_evt, loopback);
   assign tx_pending = |(~txe_q);
   assign tx_sel = sel_q;
   assign tx_byte = txb_q[sel_q][tx_byte_idx];
   assign bus_rdata = rdata_q;

   always_comb begin
      logic good;
      logic [7:0] best;
      logic [1:0] bi;
      logic found;
      logic [7:0] a;
      logic [3:0] ti;
      good = 1'b0;
      best = 8'hFF;
      bi = 2'h0;
      found = 1'b0;
      a = bus_req.addr;
      ti = 4'h0;
      bg_d = bg_q;
      fg_d = fg_q;
      txb_d = txb_q;
      local_priority_field_d = local_priority_field_q;
      rxf_d = rxf_q;
      ovr_d = ovr_q;
      bg_full_d = bg_full_q;
      txe_d = txe_q;
      abort_request_d = abort_request_q;
      abort_acknowledge_d = abort_acknowledge_q;
      rxie_d = rxie_q;
      ctl_d = ctl_q;
      sel_d = sel_q;
      busy_d = busy_q;
      rdata_d = 8'h00;
      rx_irq_req = 1'b0;
      tx_irq_req = 1'b0;
      ovr_irq_req = 1'b0;

      // software writes first; hardware sets below override them
      if (bus_req.wr) begin
         if (a < CMB_FRAME_BYTES[7:0]) begin
            // foreground is read-only to software
         end else if (a == CMB_RXFLG_OFS) begin
            if (bus_req.wdata[CMB_RXF_BIT]) begin
               rxf_d = 1'b0;
            end
            if (bus_req.wdata[CMB_OVR_BIT]) begin
               ovr_d = 1'b0;
            end
         end else if (a == CMB_RXIE_OFS) begin
            rxie_d = bus_req.wdata;
         end else if (a == CMB_TXFLG_OFS) begin
            for (int i = 0; i < TX_BUFS; i++) begin
               if (bus_req.wdata[i] && txe_q[i] && !abort_request_q[i]) begin
                  txe_d[i] = 1'b0;
                  abort_acknowledge_d[i] = 1'b0;
               end
            end
         end else if (a == CMB_TXCTL_OFS) begin
            for (int i = 0; i < TX_BUFS; i++) begin
               abort_request_d[i] = bus_req.wdata[i] && !txe_q[i];
            end
         end else if (a == CMB_CTL_OFS) begin
            ctl_d = bus_req.wdata;
         end else if (a >= CMB_TXB_BASE) begin
            ti = a[3:0];
            for (int i = 0; i < TX_BUFS; i++) begin
               if (txb_hit(a, i)) begin
                  if (ti < CMB_FRAME_BYTES[3:0]) begin
                     txb_d[i][ti] = bus_req.wdata;
                  end else if (ti == CMB_TXB_LOCAL_PRIORITY_FIELD_IDX) begin
                     local_priority_field_d[i] = bus_req.wdata;
                  end
               end
            end
         end
      end

      if (bus_req.rd) begin
         if (a < CMB_FRAME_BYTES[7:0]) begin
            rdata_d = fg_q[a[3:0]];
         end else if (a == CMB_RXFLG_OFS) begin
            rdata_d = {6'h00, ovr_q, rxf_q};
         end else if (a == CMB_RXIE_OFS) begin
            rdata_d = rxie_q;
         end else if (a == CMB_TXFLG_OFS) begin
            rdata_d = {1'b0, 3'(abort_acknowledge_q), 1'b0, 3'(txe_q)};
         end else if (a == CMB_TXCTL_OFS) begin
            rdata_d = {5'h00, 3'(abort_request_q)};
         end else if (a == CMB_CTL_OFS) begin
            rdata_d = ctl_q;
         end else if (a >= CMB_TXB_BASE) begin
            ti = a[3:0];
            for (int i = 0; i < TX_BUFS; i++) begin
               if (txb_hit(a, i)) begin
                  if (ti < CMB_FRAME_BYTES[3:0]) begin
                     rdata_d = txb_q[i][ti];
                  end else if (ti == CMB_TXB_LOCAL_PRIORITY_FIELD_IDX) begin
                     rdata_d = local_priority_field_q[i];
                  end
               end
            end
         end
      end

      // background is written by every frame, filter or not, except while both buffers are full
      if (rx_evt.byte_vld && rx_evt.byte_idx < CMB_FRAME_BYTES[3:0]) begin
         if (!(bg_full_q && rxf_q)) begin
            bg_d[rx_evt.byte_idx] = rx_evt.byte_val;
         end
      end
      if (rx_evt.frame_ok) begin
         good = rx_evt.accepted && take_frame(rx_evt, loopback);
         if (good) begin
            if (bg_full_q && rxf_q) begin
               ovr_d = 1'b1;
               ovr_irq_req = 1'b1;
            end else if (!rxf_q) begin
               fg_d = bg_d;
               rxf_d = 1'b1;
               rx_irq_req = 1'b1;
               bg_full_d = 1'b0;
            end else begin
               bg_full_d = 1'b1;
            end
         end
      end
      // a held background frame moves up once software frees foreground
      if (bg_full_q && !rxf_d) begin
         fg_d = bg_q;
         rxf_d = 1'b1;
         rx_irq_req = 1'b1;
         bg_full_d = 1'b0;
      end

      // selection repeated at each arbitration
      if (tx_evt.arb_start) begin
         for (int i = 0; i < TX_BUFS; i++) begin
            if (!txe_q[i] && (!found || local_priority_field_q[i] < best)) begin
               best = local_priority_field_q[i];
               bi = 2'(i);
               found = 1'b1;
            end
         end
         sel_d = bi;
      end
      busy_d = tx_evt.tx_busy;
      for (int i = 0; i < TX_BUFS; i++) begin
         if (tx_evt.tx_done && sel_q == 2'(i) && !txe_q[i]) begin
            txe_d[i] = 1'b1;
            abort_acknowledge_d[i] = 1'b0;
            abort_request_d[i] = 1'b0;
            tx_irq_req = 1'b1;
         end else if (abort_request_q[i] && !txe_q[i] && !(busy_q && sel_q == 2'(i))) begin
            txe_d[i] = 1'b1;
            abort_acknowledge_d[i] = 1'b1;
            abort_request_d[i] = 1'b0;
            tx_irq_req = 1'b1;
         end
      end
      rx_irq_req = rx_irq_req && rxie_q[CMB_RXF_BIT];
      ovr_irq_req = ovr_irq_req && rxie_q[CMB_OVR_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int j = 0; j < CMB_FRAME_BYTES; j++) begin
            bg_q[j] <= 8'h00;
            fg_q[j] <= 8'h00;
            for (int i = 0; i < TX_BUFS; i++) begin
               txb_q[i][j] <= 8'h00;
            end
         end
         for (int i = 0; i < TX_BUFS; i++) begin
            local_priority_field_q[i] <= CMB_LOCAL_PRIORITY_FIELD_RESET;
         end
         rxf_q <= 1'b0;
         ovr_q <= 1'b0;
         bg_full_q <= 1'b0;
         txe_q <= CMB_TXFLG_RESET[TX_BUFS-1:0];
         abort_request_q <= '0;
         abort_acknowledge_q <= '0;
         rxie_q <= CMB_RXIE_RESET;
         ctl_q <= CMB_CTL_RESET;
         rdata_q <= 8'h00;
         sel_q <= 2'h0;
         busy_q <= 1'b0;
      end else begin
         bg_q <= bg_d;
         fg_q <= fg_d;
         txb_q <= txb_d;
         local_priority_field_q <= local_priority_field_d;
         rxf_q <= rxf_d;
         ovr_q <= ovr_d;
         bg_full_q <= bg_full_d;
         txe_q <= txe_d;
         abort_request_q <= abort_request_d;
         abort_acknowledge_q <= abort_acknowledge_d;
         rxie_q <= rxie_d;
         ctl_q <= ctl_d;
         rdata_q <= rdata_d;
         sel_q <= sel_d;
         busy_q <= busy_d;
      end
   end
endmodule : cmb_msg_store

//--- src/cmb_pkg.sv
package cmb_pkg;
   localparam int unsigned CMB_FRAME_BYTES = 13;
   localparam int unsigned CMB_TX_BUFS = 3;
   localparam int unsigned CMB_LOCAL_PRIORITY_FIELD_W = 8;
   localparam logic [7:0] CMB_LOCAL_PRIORITY_FIELD_RESET = 8'h00;
   // register offsets
   localparam logic [7:0] CMB_FOREGROUND_RX_BUFFER_BASE = 8'h00;   // 13 bytes, 0x00..0x0C
   localparam logic [7:0] CMB_RXFLG_OFS = 8'h10;
   localparam logic [7:0] CMB_RXIE_OFS = 8'h11;
   localparam logic [7:0] CMB_TXFLG_OFS = 8'h12;
   localparam logic [7:0] CMB_TXCTL_OFS = 8'h13;
   localparam logic [7:0] CMB_CTL_OFS = 8'h14;
   localparam logic [7:0] CMB_TXB_BASE = 8'h20;    // buffer n at 0x20 + 0x10*n
   localparam logic [7:0] CMB_TXB_STRIDE = 8'h10;
   localparam logic [3:0] CMB_TXB_LOCAL_PRIORITY_FIELD_IDX = 4'hD;
   // rx flag register fields
   localparam int unsigned CMB_RXF_BIT = 0;
   localparam int unsigned CMB_OVR_BIT = 1;
   // control register fields
   localparam int unsigned CMB_LOOP_BIT = 0;
   localparam logic [7:0] CMB_RXIE_RESET = 8'h00;
   localparam logic [7:0] CMB_TXFLG_RESET = 8'h07;
   localparam logic [7:0] CMB_CTL_RESET = 8'h00;

   typedef logic [CMB_FRAME_BYTES*8-1:0] cmb_frame_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cmb_bus_req_t;

   // protocol engine view of one frame on the bus
   typedef struct packed {
      logic byte_vld;    // one received frame byte
      logic [3:0] byte_idx;
      logic [7:0] byte_val;
      logic frame_ok;    // end of frame reached without error
      logic accepted;    // filter verdict for this frame
      logic own;         // frame was sent by this node
      logic arb_lost;
   } cmb_rx_evt_t;

   typedef struct packed {
      logic arb_start;   // engine about to arbitrate
      logic tx_done;     // selected buffer sent successfully
      logic tx_busy;     // selected buffer on the bus
   } cmb_tx_evt_t;
endpackage : cmb_pkg

//--- test/cmb_bus_model.sv
module cmb_bus_model (
   input wire logic tx_pin, // device transmit pin
   input wire logic node_bit, // other nodes, 0 dominant
   output logic rx_pin // bus level seen by the device
);
   timeunit 1ns;
   timeprecision 1ns;
   // wired-and through the transceiver: any dominant node wins
   assign rx_pin = tx_pin & node_bit;
endmodule : cmb_bus_model

//--- test/cmb_msg_store_assertions.sv
module cmb_msg_store_assertions
   import cmb_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic reset, // sync reset
   input wire cmb_bus_req_t bus_req, // register port
   input wire logic engine_tx_bit, // engine bit
   input wire logic engine_tx_active, // engine sending
   input wire logic bus_transmit_pin, // pin out
   input wire logic loopback, // loop-back mode
   input wire cmb_rx_evt_t rx_evt, // rx events
   input wire logic ack_enable, // ack allowed
   input wire logic rx_irq_req, // rx event
   input wire cmb_tx_evt_t tx_evt, // tx events
   input wire logic tx_irq_req, // tx event
   input wire logic [1:0] tx_sel // chosen buffer
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   pin_recessive_a:
   assert property ((!engine_tx_active || loopback) |-> bus_transmit_pin)
      else $error("transmit pin not recessive");
   pin_follows_a:
   assert property (engine_tx_active && !loopback |-> bus_transmit_pin == engine_tx_bit)
      else $error("transmit pin does not follow engine");
   own_noack_a:
   assert property (rx_evt.own && !loopback && !rx_evt.arb_lost |-> !ack_enable)
      else $error("own frame acknowledged");
   loop_ack_a:
   assert property (loopback |-> ack_enable)
      else $error("loop-back frame not acknowledged");
   lost_ack_a:
   assert property (rx_evt.arb_lost |-> ack_enable)
      else $error("winning frame not acknowledged");
   own_norx_a:
   assert property (rx_evt.frame_ok && rx_evt.own && !loopback && !rx_evt.arb_lost
      && !bus_req.wr |-> !rx_irq_req [*2]) else $error("own frame raised receive event");
   done_irq_a:
   assert property (tx_evt.tx_done |-> ##[0:1] tx_irq_req)
      else $error("no transmit event after send");
   sel_hold_a:
   assert property (!tx_evt.arb_start |=> $stable(tx_sel))
      else $error("selection changed outside arbitration");
endmodule : cmb_msg_store_assertions

bind cmb_msg_store cmb_msg_store_assertions i_chk (.sys_clk, .reset, .bus_req, .engine_tx_bit,
   .engine_tx_active, .bus_transmit_pin, .loopback, .rx_evt, .ack_enable, .rx_irq_req,
   .tx_evt, .tx_irq_req, .tx_sel);

//--- test/cmb_msg_store_test.sv
module cmb_msg_store_test
   import cmb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, reset = 1'b1, engine_tx_bit = 1'b1, engine_tx_active = 1'b0;
   logic node_bit = 1'b1, bus_receive_pin, bus_transmit_pin, engine_rx_bit;
   logic ack_enable, tx_pending, loopback, rx_irq_req, tx_irq_req, ovr_irq_req;
   int rx_irq_n = 0, tx_irq_n = 0, ovr_irq_n = 0;
   cmb_bus_req_t bus_req = '0;
   cmb_rx_evt_t rx_evt = '0;
   cmb_tx_evt_t tx_evt = '0;
   logic [3:0] tx_byte_idx = 4'h0;
   logic [7:0] bus_rdata, tx_byte;
   logic [1:0] tx_sel;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   cmb_msg_store i_dut (.sys_clk, .reset, .bus_req, .bus_rdata, .bus_receive_pin,
      .engine_tx_bit, .engine_tx_active, .bus_transmit_pin, .engine_rx_bit, .rx_evt,
      .tx_evt, .ack_enable, .tx_pending, .tx_sel, .tx_byte, .tx_byte_idx, .loopback,
      .rx_irq_req, .tx_irq_req, .ovr_irq_req);
   cmb_bus_model i_bus (.tx_pin(bus_transmit_pin), .node_bit, .rx_pin(bus_receive_pin));
   task final_report;
      if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 chk(bus_rdata, e);
   endtask : rd_chk
   task frame(input logic [7:0] b, input logic acc, input logic own, input logic al);
      for (int i = 0; i < 13; i++) begin
         @(posedge sys_clk);
         rx_evt <= '{1'b1, 4'(i), b + 8'(i), 1'b0, acc, own, al};
      end
      @(posedge sys_clk);
      rx_evt <= '{1'b0, 4'h0, 8'h00, 1'b1, acc, own, al};
      @(posedge sys_clk);
      rx_evt <= '0;
   endtask : frame
   task tx(input logic s, input logic d, input logic b);
      @(posedge sys_clk);
      tx_evt <= '{s, d, b};
      @(posedge sys_clk);
      tx_evt <= '{1'b0, 1'b0, b};
      #1;
   endtask : tx
   task t_pins;
      @(posedge sys_clk);
      engine_tx_active <= 1'b1;
      engine_tx_bit <= 1'b0;
      @(posedge sys_clk);
      #1 chk({7'h0, bus_transmit_pin}, 8'h00);
      chk({7'h0, engine_rx_bit}, 8'h00);
      @(posedge sys_clk);
      engine_tx_bit <= 1'b1;
      node_bit <= 1'b0;
      @(posedge sys_clk);
      #1 chk({bus_transmit_pin, engine_rx_bit, 6'h0}, 8'h80);
      @(posedge sys_clk);
      engine_tx_active <= 1'b0;
      node_bit <= 1'b1;
   endtask : t_pins
   task t_rx;
      wr(CMB_RXIE_OFS, 8'h03);
      frame(8'h10, 1'b1, 1'b0, 1'b0);
      rd_chk(CMB_RXFLG_OFS, 8'h01);
      for (int i = 0; i < 13; i++) rd_chk(CMB_FOREGROUND_RX_BUFFER_BASE + 8'(i), 8'h10 + 8'(i));
      wr(CMB_FOREGROUND_RX_BUFFER_BASE, 8'hFF);
      rd_chk(CMB_FOREGROUND_RX_BUFFER_BASE, 8'h10);
      frame(8'h20, 1'b1, 1'b0, 1'b0);
      frame(8'h30, 1'b1, 1'b0, 1'b0);
      rd_chk(CMB_RXFLG_OFS, 8'h03);
      wr(CMB_RXFLG_OFS, 8'h00);
      rd_chk(CMB_RXFLG_OFS, 8'h03);
      // software releases the foreground; the held frame must refill it
      wr(CMB_RXFLG_OFS, 8'h03);
      rd_chk(CMB_RXFLG_OFS, 8'h01);
      rd_chk(CMB_FOREGROUND_RX_BUFFER_BASE, 8'h20);
      wr(CMB_RXFLG_OFS, 8'h01);
      rd_chk(CMB_RXFLG_OFS, 8'h00);
   endtask : t_rx
   task t_own;
      for (int m = 0; m < 3; m++) begin
         if (m == 2) wr(CMB_CTL_OFS, 8'h01);
         frame(8'h40, 1'b1, 1'b1, m == 1);
         rd_chk(CMB_RXFLG_OFS, (m == 0) ? 8'h00 : 8'h01);
         wr(CMB_RXFLG_OFS, 8'h01);
      end
      // loop-back: engine hears itself, bus stays recessive
      @(posedge sys_clk);
      engine_tx_active <= 1'b1;
      engine_tx_bit <= 1'b0;
      @(posedge sys_clk);
      #1 chk({engine_rx_bit, bus_transmit_pin, 6'h0}, 8'h40);
      @(posedge sys_clk);
      engine_tx_active <= 1'b0;
      engine_tx_bit <= 1'b1;
      wr(CMB_CTL_OFS, 8'h00);
   endtask : t_own
   task t_tx;
      for (int i = 0; i < 3; i++) begin
         wr(CMB_TXB_BASE + 8'(16 * i) + 8'(CMB_TXB_LOCAL_PRIORITY_FIELD_IDX), 8'h30 - 8'(i * 8'h10) + 8'(i));
         wr(CMB_TXB_BASE + 8'(16 * i), 8'hA0 + 8'(i));
      end
      rd_chk(CMB_TXFLG_OFS, 8'h07);
      wr(CMB_TXFLG_OFS, 8'h07);
      tx(1'b1, 1'b0, 1'b0);
      chk({6'h0, tx_sel}, 8'h02);
      chk(tx_byte, 8'hA2);
      tx(1'b0, 1'b1, 1'b0);
      rd_chk(CMB_TXFLG_OFS, 8'h04);
      tx(1'b1, 1'b0, 1'b0);
      chk({6'h0, tx_sel}, 8'h01);
      wr(CMB_TXB_BASE + 8'(CMB_TXB_LOCAL_PRIORITY_FIELD_IDX), 8'h05);
      tx(1'b1, 1'b0, 1'b0);
      chk({6'h0, tx_sel}, 8'h00);
      tx(1'b0, 1'b0, 1'b1);
      wr(CMB_TXCTL_OFS, 8'h01);
      rd_chk(CMB_TXFLG_OFS, 8'h04);
      tx(1'b0, 1'b1, 1'b0);
      rd_chk(CMB_TXFLG_OFS, 8'h05);
      wr(CMB_TXCTL_OFS, 8'h02);
      rd_chk(CMB_TXFLG_OFS, 8'h27);
      chk({7'h0, tx_pending}, 8'h00);
   endtask : t_tx
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // a hang must still reach the verdict
   always @(posedge sys_clk) begin
      if (rx_irq_req === 1'b1) rx_irq_n <= rx_irq_n + 1;
      if (tx_irq_req === 1'b1) tx_irq_n <= tx_irq_n + 1;
      if (ovr_irq_req === 1'b1) ovr_irq_n <= ovr_irq_n + 1;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      t_pins();
      t_rx();
      t_own();
      t_tx();
      @(posedge sys_clk);
      #1 chk(8'(rx_irq_n), 8'h04);
      chk(8'(ovr_irq_n), 8'h01);
      chk(8'(tx_irq_n), 8'h03);
      final_report();
   end
endmodule : cmb_msg_store_test
